// ### rtl/sasq_pkg.sv
// shared constants and types of the serial converter sequencer
package sasq_pkg;

    // data widths
    localparam int RES_BITS   = 10;
    localparam int ADDR_BITS  = 3;
    localparam int CMD_BITS   = 4;
    localparam int PAD_BITS   = 6;
    localparam int FRAME_BITS = RES_BITS + PAD_BITS;
    localparam int MAX_CH     = 8;

    // serial frame positions, counted in serial clock edges
    localparam logic [3:0] ADDR_LATCH_CNT = 4'h4;
    localparam logic [3:0] SAMPLE_END_CNT = 4'h8;
    localparam logic [4:0] FRAME_CNT      = 5'h10;

    // conversion timing, counted in conversion clock periods
    localparam logic [5:0] CONV_TICKS     = 6'h29;
    localparam logic [5:0] LAST_TICK      = CONV_TICKS - 6'h01;
    localparam logic [1:0] RESOLVE_PHASE  = 2'h3;

    // justification select bit
    localparam logic JUST_LEFT  = 1'b0;
    localparam logic JUST_RIGHT = 1'b1;

    // reset values
    localparam logic [RES_BITS-1:0]   TRIAL_RESET = 10'h200;
    localparam logic [FRAME_BITS-1:0] FRAME_RESET = 16'h0000;
    localparam logic [CMD_BITS-1:0]   CMD_RESET   = 4'h0;

    typedef enum logic [1:0] {
        SASQ_IDLE = 2'b00,
        SASQ_RUN  = 2'b01,
        SASQ_DONE = 2'b11
    } sasq_sar_state_t;

endpackage

// ### rtl/sasq_conv_if.sv
// link between the sequencer control and the approximation engine
`timescale 1ns/1ps
`default_nettype none
interface sasq_conv_if;
    logic                            start;
    logic                            tick;
    logic                            comp_high;
    logic [sasq_pkg::RES_BITS-1:0]   trial;
    logic                            done;
    logic [sasq_pkg::RES_BITS-1:0]   result;

    modport ctl (output start, output tick, output comp_high,
                 input trial, input done, input result);
    modport sar (input start, input tick, input comp_high,
                 output trial, output done, output result);
endinterface
`default_nettype wire

// ### rtl/sasq_sar.sv
// successive approximation engine paced by conversion clock ticks
`timescale 1ns/1ps
`default_nettype none
module sasq_sar (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control side
    sasq_conv_if.sar  cv
);
    import sasq_pkg::*;

    sasq_sar_state_t     state_q;
    sasq_sar_state_t     state_d;
    logic [5:0]          cnt_q;
    logic [RES_BITS-1:0] trial_q;
    logic [RES_BITS-1:0] mask_q;
    logic                done_q;

    wire running   = (state_q == SASQ_RUN);
    wire run_tick  = running & cv.tick;
    wire last_tick = run_tick & (cnt_q == LAST_TICK);
    // one bit decided every fourth period, ten bits inside the 41
    wire resolve   = run_tick & (cnt_q[1:0] == RESOLVE_PHASE) & (cnt_q != LAST_TICK);
    wire [RES_BITS-1:0] kept = cv.comp_high ? trial_q : (trial_q & ~mask_q);

    always_comb begin
        case (state_q)
            SASQ_IDLE: state_d = cv.start ? SASQ_RUN : SASQ_IDLE;
            SASQ_RUN:  state_d = cv.start ? SASQ_RUN : (last_tick ? SASQ_DONE : SASQ_RUN);
            SASQ_DONE: state_d = cv.start ? SASQ_RUN : SASQ_IDLE;
            default:   state_d = SASQ_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= SASQ_IDLE;
            cnt_q   <= '0;
            trial_q <= TRIAL_RESET;
            mask_q  <= TRIAL_RESET;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            done_q  <= last_tick & ~cv.start;
            if (cv.start) begin
                cnt_q   <= '0;
                trial_q <= TRIAL_RESET;
                mask_q  <= TRIAL_RESET;
            end else if (run_tick) begin
                cnt_q <= cnt_q + 6'h01;
                if (resolve) begin
                    trial_q <= kept | (mask_q >> 1);
                    mask_q  <= mask_q >> 1;
                end
            end
        end
    end

    assign cv.trial  = trial_q;
    assign cv.result = trial_q;
    assign cv.done   = done_q;
endmodule
`default_nettype wire

// ### rtl/sasq_top.sv
// serial converter sequencer: serial link, channel select and conversion timing
// Functional notes
// - each result is ten bits found by successive approximation.
// - one analog input is selected from four or eight by the received address.
// - the serial result is left or right justified as chosen per conversion.
// - conversion and serial exchange run on separate asynchronous clocks, crossed properly.
// - the conversion ends within 41 conversion clock periods plus 200 ns.
// - the sampling window stays open at most 4.5 serial clock periods plus 200 ns after address latch.
// - a conversion ending mid exchange reloads the output shift register with the new result, losing that transfer.
// - three address bits come first, then the justification bit, low for left.
// - right justified output leads with six zeros, sixteen periods in all.
// - status rises as sampling ends, stays 41 conversion periods, falls when the result is loaded.
// - rising serial edges shift input while selected, falling edges shift output while enabled.
`timescale 1ns/1ps
`default_nettype none
module sasq_top #(
    parameter int NUM_CH = 8
) (
    // system clock and reset
    input  wire logic                          CLK,
    input  wire logic                          SYS_RST,
    // conversion clock pin
    input  wire logic                          CONV_CLK,
    // serial link
    input  wire logic                          SERIAL_CLK,
    input  wire logic                          CS_N,
    input  wire logic                          OE_N,
    input  wire logic                          SERIAL_IN,
    output var  logic                          SERIAL_OUT,
    output var  logic                          SERIAL_OUT_EN_N,
    // analog front end
    input  wire logic                          COMP_HIGH,
    output var  logic [sasq_pkg::RES_BITS-1:0] TRIAL_CODE,
    output var  logic [NUM_CH-1:0]             CHANNEL_SEL,
    output var  logic                          SAMPLE_EN,
    // status
    output var  logic                          CONVERSION_STATUS,
    output var  logic                          OVERRUN
);
    import sasq_pkg::*;

    localparam int SEL_BITS = $clog2(NUM_CH);
    localparam int NSYNC    = 7;
    localparam int S_CONVERSION_CLOCK   = 0;
    localparam int S_COMP   = 1;
    localparam int S_CS     = 2;
    localparam int S_OE     = 3;
    localparam int S_ADDR   = 4;
    localparam int S_START  = 5;
    localparam int S_OVR    = 6;

    // ---------------- serial clock domain, rising edge ----------------
    logic                 srst1_q;
    logic                 srst2_q;
    logic [3:0]           in_cnt_q;
    logic [CMD_BITS-1:0]  cmd_sr_q;
    logic                 addr_tgl_q;

    wire in_addr   = (in_cnt_q < ADDR_LATCH_CNT);
    wire addr_last = (in_cnt_q == ADDR_LATCH_CNT - 4'h1);
    wire in_full   = (in_cnt_q == SAMPLE_END_CNT);

    // reset reaches this domain through two flops, needs running edges
    always_ff @(posedge SERIAL_CLK) begin
        srst1_q <= SYS_RST;
        srst2_q <= srst1_q;
    end

    always_ff @(posedge SERIAL_CLK) begin
        if (srst2_q || CS_N) begin
            in_cnt_q <= '0;
        end else if (!in_full) begin
            in_cnt_q <= in_cnt_q + 4'h1;
        end
    end

    // only the first four rises of a frame reach the command word
    always_ff @(posedge SERIAL_CLK) begin
        if (srst2_q) begin
            cmd_sr_q   <= CMD_RESET;
            addr_tgl_q <= 1'b0;
        end else if (!CS_N) begin
            if (in_addr) begin
                cmd_sr_q <= {SERIAL_IN, cmd_sr_q[CMD_BITS-1:1]};
            end
            if (addr_last) begin
                addr_tgl_q <= ~addr_tgl_q;
            end
        end
    end

    // ---------------- serial clock domain, falling edge ----------------
    logic                  start_tgl_q;
    logic                  start_sent_q;
    logic                  done_s1_q;
    logic                  done_s2_q;
    logic                  done_seen_q;
    logic [FRAME_BITS-1:0] out_sr_q;
    logic [4:0]            out_cnt_q;
    logic                  ovr_tgl_q;
    logic                  done_tgl_q;
    logic [FRAME_BITS-1:0] frame_q;

    wire load_frame = done_s2_q ^ done_seen_q;
    wire out_open   = ~CS_N & ~OE_N;
    wire out_more   = (out_cnt_q != FRAME_CNT);
    wire mid_xfer   = ~CS_N & (out_cnt_q != 5'h00) & out_more;
    wire shift_out  = out_open & out_more;
    wire [FRAME_BITS-1:0] out_sr_d = {out_sr_q[FRAME_BITS-2:0], 1'b0};

    // result toggle from the system clock: two flops, then an edge memory
    always_ff @(negedge SERIAL_CLK) begin
        if (srst2_q) begin
            done_s1_q   <= 1'b0;
            done_s2_q   <= 1'b0;
            done_seen_q <= 1'b0;
        end else begin
            done_s1_q   <= done_tgl_q;
            done_s2_q   <= done_s1_q;
            done_seen_q <= done_s2_q;
        end
    end

    always_ff @(negedge SERIAL_CLK) begin
        if (srst2_q) begin
            start_tgl_q  <= 1'b0;
            start_sent_q <= 1'b0;
        end else if (in_full && !start_sent_q) begin
            // half a period after the eighth rise: 4.5 periods past latch
            start_tgl_q  <= ~start_tgl_q;
            start_sent_q <= 1'b1;
        end else if (in_cnt_q == 4'h0) begin
            start_sent_q <= 1'b0;
        end
    end

    always_ff @(negedge SERIAL_CLK) begin
        if (srst2_q) begin
            out_sr_q  <= FRAME_RESET;
            out_cnt_q <= FRAME_CNT;
        end else if (load_frame) begin
            out_sr_q  <= frame_q;
            out_cnt_q <= '0;
        end else if (shift_out) begin
            out_sr_q  <= out_sr_d;
            out_cnt_q <= out_cnt_q + 5'h01;
        end
    end

    always_ff @(negedge SERIAL_CLK) begin
        if (srst2_q) begin
            ovr_tgl_q <= 1'b0;
        end else if (load_frame && mid_xfer) begin
            ovr_tgl_q <= ~ovr_tgl_q;
        end
    end

    assign SERIAL_OUT = out_sr_q[FRAME_BITS-1];

    // ---------------- system clock domain ----------------
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] prev_q;
    logic [NSYNC-1:0] async_in;

    assign async_in[S_CONVERSION_CLOCK]  = CONV_CLK;
    assign async_in[S_COMP]  = COMP_HIGH;
    assign async_in[S_CS]    = CS_N;
    assign async_in[S_OE]    = OE_N;
    assign async_in[S_ADDR]  = addr_tgl_q;
    assign async_in[S_START] = start_tgl_q;
    assign async_in[S_OVR]   = ovr_tgl_q;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    prev_q[gi]  <= 1'b0;
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi]  <= sync2_q[gi];
                end
            end
        end
    endgenerate

    wire conv_tick = sync2_q[S_CONVERSION_CLOCK] & ~prev_q[S_CONVERSION_CLOCK];
    wire addr_evt  = sync2_q[S_ADDR] ^ prev_q[S_ADDR];
    wire start_evt = sync2_q[S_START] ^ prev_q[S_START];
    wire ovr_evt   = sync2_q[S_OVR] ^ prev_q[S_OVR];

    // command word is stable for over four serial periods when its toggle lands
    wire [SEL_BITS-1:0] sel_idx     = cmd_sr_q[SEL_BITS-1:0];
    wire                cmd_just    = cmd_sr_q[CMD_BITS-1];
    wire [NUM_CH-1:0]   chan_onehot = {{(NUM_CH-1){1'b0}}, 1'b1} << sel_idx;

    sasq_conv_if cv ();

    logic                start_q;
    logic [NUM_CH-1:0]   chan_q;
    logic                sample_q;
    logic                just_cmd_q;
    logic                just_conv_q;
    logic                status_q;
    logic                overrun_q;
    logic                oe_pin_n_q;
    logic [RES_BITS-1:0] trial_out_q;

    wire [FRAME_BITS-1:0] frame_right = {{PAD_BITS{1'b0}}, cv.result};
    wire [FRAME_BITS-1:0] frame_left  = {cv.result, {PAD_BITS{1'b0}}};
    wire [FRAME_BITS-1:0] frame_d     = (just_conv_q == JUST_RIGHT) ? frame_right : frame_left;

    assign cv.start     = start_q;
    assign cv.tick      = conv_tick;
    assign cv.comp_high = sync2_q[S_COMP];

    sasq_sar u_sar (
        .clk (CLK),
        .rst (SYS_RST),
        .cv  (cv.sar)
    );

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            chan_q     <= {{(NUM_CH-1){1'b0}}, 1'b1};
            just_cmd_q <= JUST_LEFT;
            sample_q   <= 1'b0;
        end else if (addr_evt) begin
            chan_q     <= chan_onehot;
            just_cmd_q <= cmd_just;
            sample_q   <= 1'b1;
        end else if (start_evt) begin
            sample_q   <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            start_q     <= 1'b0;
            just_conv_q <= JUST_LEFT;
            status_q    <= 1'b0;
        end else begin
            start_q <= start_evt;
            if (start_evt) begin
                just_conv_q <= just_cmd_q;
                status_q    <= 1'b1;
            end else if (cv.done) begin
                status_q    <= 1'b0;
            end
        end
    end

    // result parked here; the falling serial edge picks it up after the toggle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            frame_q    <= FRAME_RESET;
            done_tgl_q <= 1'b0;
        end else if (cv.done) begin
            frame_q    <= frame_d;
            done_tgl_q <= ~done_tgl_q;
        end
    end

    // a new overrun wins over the clear of a new address
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            overrun_q <= 1'b0;
        end else begin
            overrun_q <= ovr_evt | (overrun_q & ~addr_evt);
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            oe_pin_n_q <= 1'b1;
        end else begin
            oe_pin_n_q <= sync2_q[S_CS] | sync2_q[S_OE];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            trial_out_q <= TRIAL_RESET;
        end else begin
            trial_out_q <= cv.trial;
        end
    end

    assign CHANNEL_SEL       = chan_q;
    assign SAMPLE_EN         = sample_q;
    assign CONVERSION_STATUS = status_q;
    assign OVERRUN           = overrun_q;
    assign SERIAL_OUT_EN_N   = oe_pin_n_q;
    assign TRIAL_CODE        = trial_out_q;
endmodule
`default_nettype wire

// ### sim/sasq_top_properties.sv
// concurrent checks on the sequencer's top level ports
`timescale 1ns/1ps
`default_nettype none
module sasq_top_properties #(
    parameter int NUM_CH = 8
) (
    // clocks and reset
    input wire logic                          CLK,
    input wire logic                          SYS_RST,
    input wire logic                          CONV_CLK,
    // link control
    input wire logic                          CS_N,
    input wire logic                          OE_N,
    input wire logic                          SERIAL_OUT_EN_N,
    // converter and status
    input wire logic [sasq_pkg::RES_BITS-1:0] TRIAL_CODE,
    input wire logic [NUM_CH-1:0]             CHANNEL_SEL,
    input wire logic                          SAMPLE_EN,
    input wire logic                          CONVERSION_STATUS,
    input wire logic                          OVERRUN
);
    import sasq_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic       conv_q;
    logic [6:0] tick_q;
    logic [7:0] samp_q;
    // raw edge count; the design's synchroniser may lag this by one tick
    always_ff @(posedge CLK) begin
        conv_q <= CONV_CLK;
        tick_q <= (SYS_RST || !CONVERSION_STATUS) ? 7'h00 : tick_q + 7'(CONV_CLK && !conv_q);
        samp_q <= (SYS_RST || !SAMPLE_EN) ? 8'h00 : samp_q + 8'h01;
    end
    property p_chan_onehot;
        $onehot(CHANNEL_SEL);
    endproperty
    a_chan_onehot: assert property (p_chan_onehot) else $error("channel select not one-hot");
    property p_chan_change;
        !$stable(CHANNEL_SEL) |-> ##[0:1] SAMPLE_EN;
    endproperty
    a_chan_change: assert property (p_chan_change) else $error("channel changed outside sampling");
    property p_conv_len;
        $fell(CONVERSION_STATUS) |-> tick_q >= 7'h28 && tick_q <= 7'h2a;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("status high for wrong tick count");
    property p_sample_max;
        samp_q <= 8'h46;
    endproperty
    a_sample_max: assert property (p_sample_max) else $error("sampling window too long");
    property p_trial_start;
        $rose(CONVERSION_STATUS) |-> ##2 TRIAL_CODE == TRIAL_RESET;
    endproperty
    a_trial_start: assert property (p_trial_start) else $error("trial code not at midscale");
    property p_out_off;
        (CS_N || OE_N) [*4] |-> SERIAL_OUT_EN_N;
    endproperty
    a_out_off: assert property (p_out_off) else $error("output driven while deselected");
    property p_out_on;
        (!CS_N && !OE_N) [*5] |-> !SERIAL_OUT_EN_N;
    endproperty
    a_out_on: assert property (p_out_on) else $error("output not driven while enabled");
    property p_overrun;
        $rose(OVERRUN) |-> !CONVERSION_STATUS && !SAMPLE_EN;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun outside result load");
endmodule
bind sasq_top sasq_top_properties #(.NUM_CH(NUM_CH)) u_props (.CLK(CLK), .SYS_RST(SYS_RST), .CONV_CLK(CONV_CLK),
    .CS_N(CS_N), .OE_N(OE_N), .SERIAL_OUT_EN_N(SERIAL_OUT_EN_N), .TRIAL_CODE(TRIAL_CODE),
    .CHANNEL_SEL(CHANNEL_SEL), .SAMPLE_EN(SAMPLE_EN), .CONVERSION_STATUS(CONVERSION_STATUS), .OVERRUN(OVERRUN));
`default_nettype wire

// ### sim/sasq_host_model.sv
// host model: free running link clock and frame transfers
`timescale 1ns/1ps
`default_nettype none
module sasq_host_model (
    // link outputs
    output logic      sclk,
    output logic      cs_n,
    output logic      oe_n,
    output logic      sdi,
    // device side
    input  wire logic sdo,
    input  wire logic conv_status
);
    // free running and far faster than the conversion clock needs
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        oe_n = 1'b1;
        sdi  = 1'b0;
        #13;
        forever #40 sclk = ~sclk;
    end
    // command bits go out first; oe_len limits how many result bits shift
    task automatic frame(input logic [3:0] cmd, input int oe_len, input bit stay, output logic [15:0] rx);
        @(negedge sclk);
        cs_n <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            oe_n <= (k < oe_len) ? 1'b0 : 1'b1;
            sdi  <= (k < 4) ? cmd[k] : ~sdi;
            @(posedge sclk);
            rx = {rx[14:0], sdo};
            @(negedge sclk);
        end
        // holding the select across the load is an overrun on purpose
        if (stay) begin
            @(negedge conv_status);
            repeat (6) @(negedge sclk);
        end
        cs_n <= 1'b1;
        oe_n <= 1'b1;
        sdi  <= ~sdi;
    endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench of the serial converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sasq_pkg::*;
    logic                clk;
    logic                sys_rst = 1'b1;
    logic                conv_clk;
    logic                comp_high = 1'b0;
    logic                sclk, cs_n, oe_n, sdi, sdo, sdo_en_n;
    logic [RES_BITS-1:0] trial;
    logic [MAX_CH-1:0]   ch_sel;
    logic                sample_en, conv_status, overrun;
    logic [RES_BITS-1:0] ain_sel;
    realtime             t_rise;
    int                  bad_count = 0;
    int                  cmp_count = 0;
    // corner levels per channel
    logic [RES_BITS-1:0] ain [MAX_CH] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa, 10'h200, 10'h1ff, 10'h001, 10'h3fe};
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        conv_clk = 1'b0;
        #37.5;
        forever #125 conv_clk = ~conv_clk;
    end
    always_comb begin
        ain_sel = 10'h000;
        for (int i = 0; i < MAX_CH; i++)
            if (ch_sel[i]) ain_sel = ain[i];
    end
    always @(negedge clk) comp_high <= (ain_sel >= trial);
    always @(posedge conv_status) t_rise = $realtime;
    sasq_top #(.NUM_CH(MAX_CH)) u_dut (.CLK(clk), .SYS_RST(sys_rst), .CONV_CLK(conv_clk), .SERIAL_CLK(sclk),
        .CS_N(cs_n), .OE_N(oe_n), .SERIAL_IN(sdi), .SERIAL_OUT(sdo), .SERIAL_OUT_EN_N(sdo_en_n),
        .COMP_HIGH(comp_high), .TRIAL_CODE(trial), .CHANNEL_SEL(ch_sel), .SAMPLE_EN(sample_en),
        .CONVERSION_STATUS(conv_status), .OVERRUN(overrun));
    sasq_host_model u_host (.sclk(sclk), .cs_n(cs_n), .oe_n(oe_n), .sdi(sdi), .sdo(sdo), .conv_status(conv_status));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] framed(input logic [3:0] cmd);
        return cmd[3] ? {6'h00, ain[cmd[2:0]]} : {ain[cmd[2:0]], 6'h00};
    endfunction
    // bounded wait for conversion end, then room for the result load
    task automatic wait_done();
        realtime dur;
        for (int n = 0; n < 4000 && conv_status === 1'b1; n++) @(negedge clk);
        dur = $realtime - t_rise;
        chk("conversion end", 16'h0000, 16'(conv_status));
        chk("conversion time", 16'h0001, 16'(dur <= 41 * 250 + 200 && dur >= 9900));
        repeat (6) @(negedge sclk);
    endtask
    task automatic t_channels();
        logic [15:0] rx;
        logic [3:0]  cmd;
        logic [3:0]  prev;
        prev = 4'h0;
        for (int i = 0; i <= MAX_CH; i++) begin
            cmd = {i[0], i[2:0]};
            u_host.frame(cmd, 16, 1'b0, rx);
            if (i == 0)
                chk("first frame", FRAME_RESET, rx);
            else
                chk("result frame", framed(prev), rx);
            chk("channel select", 16'h0001 << cmd[2:0], 16'(ch_sel));
            chk("status running", 16'h0001, 16'(conv_status));
            repeat (5) @(negedge clk);
            chk("output released", 16'h0001, 16'(sdo_en_n));
            wait_done();
            prev = cmd;
        end
        $display("test channels done");
    endtask
    task automatic t_overrun();
        logic [15:0] rx;
        u_host.frame(4'hd, 4, 1'b1, rx);
        repeat (5) @(negedge clk);
        chk("overrun flag", 16'h0001, 16'(overrun));
        u_host.frame(4'h2, 16, 1'b0, rx);
        chk("frame after overrun", framed(4'hd), rx);
        chk("overrun cleared", 16'h0000, 16'(overrun));
        wait_done();
        $display("test overrun done");
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // link domain resets through its own synchroniser, so reset spans link edges
    initial begin
        repeat (32) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge sclk);
        t_channels();
        t_overrun();
        wrap_up();
    end
    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
